// File: src/cpu_regsec_pkg.sv
// constants, opcodes and types shared by the register section and its ALU
package cpu_regsec_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // machine cycle: five system clocks, two in phase one, three in phase two
   localparam logic [2:0] PHASE_ONE_SLOT = 3'h0;
   localparam logic [2:0] PHASE_TWO_FIRST = 3'h2;
   localparam logic [2:0] LATCH_SLOT = 3'h4;
   localparam logic [2:0] CYCLE_LAST_SLOT = 3'h4;
   localparam logic [2:0] SLOT_RESET = 3'h2;
   localparam logic [2:0] SLOT_STEP = 3'h1;

   ////////////////////////////////////////////////////////////////////////////
   // values after reset, plus fixed operands and the counter step
   localparam logic [15:0] RESET_PC = 16'h0000;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] STACK_RESET = 8'hFF;
   localparam logic [7:0] DATA_IDLE = 8'h00;
   localparam logic [7:0] ALL_ONES = 8'hFF;
   localparam logic [7:0] ZERO_PAGE = 8'h00;
   localparam logic [15:0] PC_STEP = 16'h0001;

   ////////////////////////////////////////////////////////////////////////////
   // opcodes of the reduced instruction set
   localparam logic [7:0] OP_NOP = 8'h00;
   localparam logic [7:0] OP_LOAD_ACC_IMM = 8'h01;
   localparam logic [7:0] OP_LOAD_X_IMM = 8'h02;
   localparam logic [7:0] OP_LOAD_Y_IMM = 8'h03;
   localparam logic [7:0] OP_ADD_IMM = 8'h04;
   localparam logic [7:0] OP_AND_IMM = 8'h05;
   localparam logic [7:0] OP_OR_IMM = 8'h06;
   localparam logic [7:0] OP_XOR_IMM = 8'h07;
   localparam logic [7:0] OP_INC_X = 8'h08;
   localparam logic [7:0] OP_DEC_X = 8'h09;
   localparam logic [7:0] OP_INC_Y = 8'h0A;
   localparam logic [7:0] OP_DEC_Y = 8'h0B;
   localparam logic [7:0] OP_X_TO_STACK = 8'h0C;
   localparam logic [7:0] OP_STACK_TO_X = 8'h0D;
   localparam logic [7:0] OP_ACC_TO_X = 8'h0E;
   localparam logic [7:0] OP_X_TO_ACC = 8'h0F;
   localparam logic [7:0] OP_LOAD_ACC_ABS = 8'h10;
   localparam logic [7:0] OP_STORE_ACC_ABS = 8'h11;
   localparam logic [7:0] OP_JUMP_ABS = 8'h12;
   localparam logic [7:0] OP_STORE_ACC_ZPX = 8'h13;
   localparam logic [7:0] OP_CLEAR_CARRY = 8'h14;
   localparam logic [7:0] OP_SET_CARRY = 8'h15;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {ALU_ADD, ALU_AND, ALU_OR, ALU_XOR} alu_op_t;
   typedef enum logic [1:0] {FETCH_STATE, STEP1, STEP2, STEP3} cycle_state_t;
   typedef enum logic [2:0] {DEST_NONE, DEST_ACC, DEST_X, DEST_Y} alu_dest_t;

endpackage : cpu_regsec_pkg

// File: src/alu_unit.sv
// eight-bit combinational ALU of the register section
`timescale 1ns/100ps
module alu_unit (
   // operands and function
   input wire logic [7:0] operandA,
   input wire logic [7:0] operandB,
   input wire logic carryIn,
   input wire cpu_regsec_pkg::alu_op_t aluOp,
   // result
   output logic [7:0] result,
   output logic carryOut
);

   logic [8:0] wideSum;

   // no storage here: the caller registers operands and takes the result next cycle
   always_comb begin
      wideSum = {1'b0, operandA} + {1'b0, operandB} + {8'h00, carryIn};
      carryOut = 1'b0;
      case (aluOp)
         cpu_regsec_pkg::ALU_ADD: begin
            result = wideSum[7:0];
            carryOut = wideSum[8];
         end
         cpu_regsec_pkg::ALU_AND: result = operandA & operandB;
         cpu_regsec_pkg::ALU_OR: result = operandA | operandB;
         cpu_regsec_pkg::ALU_XOR: result = operandA ^ operandB;
         default: result = operandA;
      endcase
   end

endmodule : alu_unit

// File: src/cpu_register_section.sv
// register section and external bus interface of an 8-bit processor
//
// Notes on behaviour
// RULE1: cycle state resets to fetch, steps each cycle
// RULE2: transfers decoded from instruction and cycle state
// RULE3: opcode from data bus loads instruction register
// RULE4: data bus latched each phase two, used next
// RULE5: internal transfers happen in phase one
// RULE6: operand and accumulator into ALU, result next
// RULE7: fetch address is program counter high:low
// RULE8: program counter increments itself per program byte
// RULE9: other increments and decrements go through ALU
// RULE10: ALU result stored the cycle after operands
// RULE11: ALU inputs from buses or zero
// RULE12: accumulator is eight bits, main ALU operand
// RULE13: stack pointer and index registers, eight bits
// RULE14: address bus always carries a defined address
// RULE15: address changes in phase one, then holds
// RULE16: reduced variants mask upper address lines
// RULE17: data pins tri-state unless transferring out
// RULE18: data bus driven only in phase two
// RULE19: read-not-write high except writes, phase-one changes
// RULE20: two phases as enables from one clock
`timescale 1ns/100ps
module cpu_register_section #(
   parameter int ADDR_LINES = 16
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // address bus and direction
   output logic [15:0] addressLines,
   output logic readNotWrite,
   output logic validAddressPin,
   // data bus pins as input, output and enable
   input wire logic [7:0] dataLinesIn,
   output logic [7:0] dataLinesOut,
   output logic [7:0] dataLinesOe_n,
   // clock phases for the support chips
   output logic phaseOne,
   output logic phaseTwo
);

   localparam logic [15:0] ADDR_MASK = 16'((32'h1 << ADDR_LINES) - 1);

   // keeps only the address lines that the variant brings out
   function automatic logic [15:0] maskAddr(input logic [15:0] addr);
      maskAddr = addr & ADDR_MASK; // RULE16
   endfunction : maskAddr

   // zero flag of a value going into a register
   function automatic logic isZero(input logic [7:0] value);
      isZero = (value == 8'h00);
   endfunction : isZero

   ////////////////////////////////////////////////////////////////////////////
   // state

   logic [2:0] slot_reg;
   logic [7:0] dataSync1_reg;
   logic [7:0] dataSync2_reg;
   logic [7:0] inputDataLatch_reg;
   logic [7:0] instruction_reg;
   cpu_regsec_pkg::cycle_state_t state_reg;
   logic [7:0] programCounterLow_reg;
   logic [7:0] programCounterHigh_reg;
   logic [7:0] addressLatchLow_reg;
   logic [7:0] addressLatchHigh_reg;
   logic [7:0] accumulator_reg;
   logic [7:0] indexX_reg;
   logic [7:0] indexY_reg;
   logic [7:0] stackPointer_reg;
   logic [7:0] operandLow_reg;
   logic carry_reg;
   logic zero_reg;
   logic negative_reg;
   logic readNotWrite_reg;
   logic [7:0] dataOut_reg;
   logic [7:0] aluInA_reg;
   logic [7:0] aluInB_reg;
   logic aluCarryIn_reg;
   cpu_regsec_pkg::alu_op_t aluOp_reg;
   cpu_regsec_pkg::alu_dest_t aluDest_reg;
   logic [7:0] aluResult;
   logic aluCarryOut;
   logic phaseOneStep;
   logic latchStep;

   ////////////////////////////////////////////////////////////////////////////
   // phase generation

   // slot counter splits each machine cycle into two phase-one and three phase-two clocks
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         slot_reg <= cpu_regsec_pkg::SLOT_RESET;
      end else if (slot_reg == cpu_regsec_pkg::CYCLE_LAST_SLOT) begin
         slot_reg <= cpu_regsec_pkg::PHASE_ONE_SLOT;
      end else begin
         slot_reg <= slot_reg + cpu_regsec_pkg::SLOT_STEP;
      end
   end

   // phases never overlap, so the bus can be released cleanly between them
   assign phaseOne = (slot_reg < cpu_regsec_pkg::PHASE_TWO_FIRST); // RULE20
   assign phaseTwo = !phaseOne; // RULE20
   assign phaseOneStep = (slot_reg == cpu_regsec_pkg::PHASE_ONE_SLOT); // RULE20
   assign latchStep = (slot_reg == cpu_regsec_pkg::LATCH_SLOT); // RULE20

   ////////////////////////////////////////////////////////////////////////////
   // data bus input path

   // pins come from outside, so two flops before anything reads them
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         dataSync1_reg <= cpu_regsec_pkg::DATA_IDLE;
         dataSync2_reg <= cpu_regsec_pkg::DATA_IDLE;
      end else begin
         dataSync1_reg <= dataLinesIn;
         dataSync2_reg <= dataSync1_reg;
      end
   end

   // three phase-two clocks leave room for the synchroniser before the trap
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         inputDataLatch_reg <= cpu_regsec_pkg::OP_NOP;
      end else if (latchStep) begin
         inputDataLatch_reg <= dataSync2_reg; // RULE4
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // ALU

   alu_unit aluInst (
      .operandA(aluInA_reg),
      .operandB(aluInB_reg),
      .carryIn(aluCarryIn_reg),
      .aluOp(aluOp_reg),
      .result(aluResult),
      .carryOut(aluCarryOut)
   );

   ////////////////////////////////////////////////////////////////////////////
   // cycle decode

   logic [7:0] opcode;
   logic [15:0] pcCur;
   logic [15:0] fetchAddr;
   logic doFetch;
   logic nzLoad;
   logic [7:0] nzValue;
   cpu_regsec_pkg::cycle_state_t stateNext;
   logic [7:0] instructionNext;
   logic [15:0] pcNext;
   logic [15:0] addressNext;
   logic readNotWriteNext;
   logic [7:0] dataOutNext;
   logic [7:0] operandLowNext;
   logic [7:0] accNext;
   logic [7:0] xNext;
   logic [7:0] yNext;
   logic [7:0] stackNext;
   logic carryNext;
   logic [7:0] aluInANext;
   logic [7:0] aluInBNext;
   logic aluCarryInNext;
   cpu_regsec_pkg::alu_op_t aluOpNext;
   cpu_regsec_pkg::alu_dest_t aluDestNext;

   assign pcCur = {programCounterHigh_reg, programCounterLow_reg};
   // the opcode is still in the latch during the cycle that follows its fetch
   assign opcode = (state_reg == cpu_regsec_pkg::FETCH_STATE) ? inputDataLatch_reg : instruction_reg; // RULE2

   // every cycle issues a defined address: next program byte, a dummy reread, or an operand
   always_comb begin
      stateNext = cpu_regsec_pkg::FETCH_STATE;
      instructionNext = instruction_reg;
      pcNext = pcCur;
      addressNext = {addressLatchHigh_reg, addressLatchLow_reg};
      readNotWriteNext = 1'b1; // RULE19
      dataOutNext = dataOut_reg;
      operandLowNext = operandLow_reg;
      accNext = accumulator_reg;
      xNext = indexX_reg;
      yNext = indexY_reg;
      stackNext = stackPointer_reg;
      carryNext = carry_reg;
      aluInANext = aluInA_reg;
      aluInBNext = aluInB_reg;
      aluCarryInNext = 1'b0;
      aluOpNext = aluOp_reg;
      aluDestNext = cpu_regsec_pkg::DEST_NONE;
      fetchAddr = pcCur;
      doFetch = 1'b0;
      nzLoad = 1'b0;
      nzValue = aluResult;
      // result computed from last cycle's operands is stored now
      case (aluDest_reg)
         cpu_regsec_pkg::DEST_ACC: begin
            accNext = aluResult; // RULE10
            nzLoad = 1'b1;
            if (aluOp_reg == cpu_regsec_pkg::ALU_ADD) begin
               carryNext = aluCarryOut;
            end
         end
         cpu_regsec_pkg::DEST_X: begin
            xNext = aluResult; // RULE10
            nzLoad = 1'b1;
         end
         cpu_regsec_pkg::DEST_Y: begin
            yNext = aluResult; // RULE10
            nzLoad = 1'b1;
         end
         default: nzLoad = 1'b0;
      endcase
      case (state_reg)
         cpu_regsec_pkg::FETCH_STATE: begin
            instructionNext = inputDataLatch_reg; // RULE3
            stateNext = cpu_regsec_pkg::STEP1; // RULE1
            addressNext = pcCur; // RULE14
            aluInBNext = 8'h00; // RULE11
            aluOpNext = cpu_regsec_pkg::ALU_ADD;
            case (opcode)
               cpu_regsec_pkg::OP_INC_X, cpu_regsec_pkg::OP_DEC_X: begin
                  aluInANext = indexX_reg; // RULE9
                  aluDestNext = cpu_regsec_pkg::DEST_X;
               end
               cpu_regsec_pkg::OP_INC_Y, cpu_regsec_pkg::OP_DEC_Y: begin
                  aluInANext = indexY_reg; // RULE9
                  aluDestNext = cpu_regsec_pkg::DEST_Y;
               end
               cpu_regsec_pkg::OP_LOAD_ACC_IMM, cpu_regsec_pkg::OP_LOAD_X_IMM, cpu_regsec_pkg::OP_LOAD_Y_IMM,
               cpu_regsec_pkg::OP_ADD_IMM, cpu_regsec_pkg::OP_AND_IMM, cpu_regsec_pkg::OP_OR_IMM,
               cpu_regsec_pkg::OP_XOR_IMM, cpu_regsec_pkg::OP_LOAD_ACC_ABS, cpu_regsec_pkg::OP_STORE_ACC_ABS,
               cpu_regsec_pkg::OP_JUMP_ABS, cpu_regsec_pkg::OP_STORE_ACC_ZPX: begin
                  pcNext = pcCur + cpu_regsec_pkg::PC_STEP; // RULE8
               end
               default: pcNext = pcCur; // single-byte opcodes reread the next byte
            endcase
            // decrement adds all ones, increment adds zero with carry in
            case (opcode)
               cpu_regsec_pkg::OP_DEC_X, cpu_regsec_pkg::OP_DEC_Y: aluInBNext = cpu_regsec_pkg::ALL_ONES; // RULE9
               cpu_regsec_pkg::OP_INC_X, cpu_regsec_pkg::OP_INC_Y: aluCarryInNext = 1'b1; // RULE9
               default: aluCarryInNext = 1'b0;
            endcase
         end
         cpu_regsec_pkg::STEP1: begin
            doFetch = 1'b1;
            case (instruction_reg)
               cpu_regsec_pkg::OP_LOAD_ACC_IMM: begin
                  accNext = inputDataLatch_reg; // RULE5
                  nzLoad = 1'b1;
                  nzValue = inputDataLatch_reg;
               end
               cpu_regsec_pkg::OP_LOAD_X_IMM: begin
                  xNext = inputDataLatch_reg; // RULE13
                  nzLoad = 1'b1;
                  nzValue = inputDataLatch_reg;
               end
               cpu_regsec_pkg::OP_LOAD_Y_IMM: begin
                  yNext = inputDataLatch_reg; // RULE13
                  nzLoad = 1'b1;
                  nzValue = inputDataLatch_reg;
               end
               cpu_regsec_pkg::OP_ADD_IMM, cpu_regsec_pkg::OP_AND_IMM, cpu_regsec_pkg::OP_OR_IMM,
               cpu_regsec_pkg::OP_XOR_IMM: begin
                  aluInANext = accumulator_reg; // RULE6
                  aluInBNext = inputDataLatch_reg; // RULE6
                  aluDestNext = cpu_regsec_pkg::DEST_ACC; // RULE12
                  case (instruction_reg)
                     cpu_regsec_pkg::OP_ADD_IMM: begin
                        aluOpNext = cpu_regsec_pkg::ALU_ADD;
                        aluCarryInNext = carry_reg;
                     end
                     cpu_regsec_pkg::OP_AND_IMM: aluOpNext = cpu_regsec_pkg::ALU_AND;
                     cpu_regsec_pkg::OP_OR_IMM: aluOpNext = cpu_regsec_pkg::ALU_OR;
                     default: aluOpNext = cpu_regsec_pkg::ALU_XOR;
                  endcase
               end
               cpu_regsec_pkg::OP_X_TO_STACK: stackNext = indexX_reg; // RULE13
               cpu_regsec_pkg::OP_STACK_TO_X: begin
                  xNext = stackPointer_reg;
                  nzLoad = 1'b1;
                  nzValue = stackPointer_reg;
               end
               cpu_regsec_pkg::OP_ACC_TO_X: begin
                  xNext = accumulator_reg;
                  nzLoad = 1'b1;
                  nzValue = accumulator_reg;
               end
               cpu_regsec_pkg::OP_X_TO_ACC: begin
                  accNext = indexX_reg;
                  nzLoad = 1'b1;
                  nzValue = indexX_reg;
               end
               cpu_regsec_pkg::OP_CLEAR_CARRY: carryNext = 1'b0;
               cpu_regsec_pkg::OP_SET_CARRY: carryNext = 1'b1;
               cpu_regsec_pkg::OP_LOAD_ACC_ABS, cpu_regsec_pkg::OP_STORE_ACC_ABS, cpu_regsec_pkg::OP_JUMP_ABS: begin
                  doFetch = 1'b0;
                  operandLowNext = inputDataLatch_reg;
                  addressNext = pcCur; // RULE14
                  pcNext = pcCur + cpu_regsec_pkg::PC_STEP; // RULE8
                  stateNext = cpu_regsec_pkg::STEP2; // RULE1
               end
               cpu_regsec_pkg::OP_STORE_ACC_ZPX: begin
                  // index added in the ALU; the bus rereads the program meanwhile
                  doFetch = 1'b0;
                  aluInANext = inputDataLatch_reg; // RULE11
                  aluInBNext = indexX_reg; // RULE13
                  aluOpNext = cpu_regsec_pkg::ALU_ADD;
                  addressNext = pcCur; // RULE14
                  stateNext = cpu_regsec_pkg::STEP2; // RULE1
               end
               default: doFetch = 1'b1;
            endcase
         end
         cpu_regsec_pkg::STEP2: begin
            stateNext = cpu_regsec_pkg::STEP3; // RULE1
            case (instruction_reg)
               cpu_regsec_pkg::OP_LOAD_ACC_ABS: addressNext = {inputDataLatch_reg, operandLow_reg};
               cpu_regsec_pkg::OP_STORE_ACC_ABS: begin
                  addressNext = {inputDataLatch_reg, operandLow_reg};
                  readNotWriteNext = 1'b0; // RULE19
                  dataOutNext = accumulator_reg;
               end
               cpu_regsec_pkg::OP_STORE_ACC_ZPX: begin
                  addressNext = {cpu_regsec_pkg::ZERO_PAGE, aluResult}; // RULE10
                  readNotWriteNext = 1'b0; // RULE19
                  dataOutNext = accumulator_reg;
               end
               default: begin
                  fetchAddr = {inputDataLatch_reg, operandLow_reg};
                  doFetch = 1'b1;
               end
            endcase
         end
         default: begin
            doFetch = 1'b1;
            if (instruction_reg == cpu_regsec_pkg::OP_LOAD_ACC_ABS) begin
               accNext = inputDataLatch_reg; // RULE5
               nzLoad = 1'b1;
               nzValue = inputDataLatch_reg;
            end
         end
      endcase
      // next cycle is an opcode fetch at the counter or the jump target; the counter goes one past it
      if (doFetch) begin
         stateNext = cpu_regsec_pkg::FETCH_STATE; // RULE1
         addressNext = fetchAddr; // RULE7
         pcNext = fetchAddr + cpu_regsec_pkg::PC_STEP; // RULE8
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // phase-one register transfers

   // sequencing state
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_reg <= cpu_regsec_pkg::FETCH_STATE;
         instruction_reg <= cpu_regsec_pkg::OP_NOP;
         operandLow_reg <= cpu_regsec_pkg::REG_RESET;
      end else if (phaseOneStep) begin
         state_reg <= stateNext; // RULE1
         instruction_reg <= instructionNext; // RULE3
         operandLow_reg <= operandLowNext;
      end
   end

   // program counter, counting on its own incrementer
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         programCounterLow_reg <= cpu_regsec_pkg::RESET_PC[7:0] + 8'h01;
         programCounterHigh_reg <= cpu_regsec_pkg::RESET_PC[15:8];
      end else if (phaseOneStep) begin
         programCounterLow_reg <= pcNext[7:0]; // RULE8
         programCounterHigh_reg <= pcNext[15:8]; // RULE8
      end
   end

   // accumulator, index registers, stack pointer and flags
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         accumulator_reg <= cpu_regsec_pkg::REG_RESET;
         indexX_reg <= cpu_regsec_pkg::REG_RESET;
         indexY_reg <= cpu_regsec_pkg::REG_RESET;
         stackPointer_reg <= cpu_regsec_pkg::STACK_RESET;
         carry_reg <= 1'b0;
         zero_reg <= 1'b0;
         negative_reg <= 1'b0;
      end else if (phaseOneStep) begin
         accumulator_reg <= accNext; // RULE12
         indexX_reg <= xNext; // RULE13
         indexY_reg <= yNext; // RULE13
         stackPointer_reg <= stackNext; // RULE13
         carry_reg <= carryNext;
         if (nzLoad) begin
            zero_reg <= isZero(nzValue);
            negative_reg <= nzValue[7];
         end
      end
   end

   // ALU operand latches keep their values until a cycle loads new ones; carry in and destination last one cycle
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         aluInA_reg <= cpu_regsec_pkg::REG_RESET;
         aluInB_reg <= cpu_regsec_pkg::REG_RESET;
         aluCarryIn_reg <= 1'b0;
         aluOp_reg <= cpu_regsec_pkg::ALU_ADD;
         aluDest_reg <= cpu_regsec_pkg::DEST_NONE;
      end else if (phaseOneStep) begin
         aluInA_reg <= aluInANext; // RULE11
         aluInB_reg <= aluInBNext; // RULE11
         aluCarryIn_reg <= aluCarryInNext;
         aluOp_reg <= aluOpNext;
         aluDest_reg <= aluDestNext; // RULE10
      end
   end

   // address, direction and write data change only at the phase-one step
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         addressLatchLow_reg <= cpu_regsec_pkg::RESET_PC[7:0];
         addressLatchHigh_reg <= cpu_regsec_pkg::RESET_PC[15:8];
         readNotWrite_reg <= 1'b1;
         dataOut_reg <= cpu_regsec_pkg::DATA_IDLE;
      end else if (phaseOneStep) begin
         addressLatchLow_reg <= addressNext[7:0]; // RULE15
         addressLatchHigh_reg <= addressNext[15:8]; // RULE15
         readNotWrite_reg <= readNotWriteNext; // RULE19
         dataOut_reg <= dataOutNext;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pins

   assign addressLines = maskAddr({addressLatchHigh_reg, addressLatchLow_reg}); // RULE16
   assign readNotWrite = readNotWrite_reg;
   // always-known addresses make a qualifier pointless, so it stays high
   assign validAddressPin = 1'b1;
   assign dataLinesOut = dataOut_reg;
   // drive only in phase two of a write; the bus floats all of phase one
   assign dataLinesOe_n = {8{!(phaseTwo && !readNotWrite_reg)}}; // RULE17 RULE18

endmodule : cpu_register_section

// File: sim/cpu_regsec_checker.sv
// concurrent checks on the register section's bus pins
`timescale 1ns/100ps
module cpu_regsec_checker #(
   parameter int ADDR_LINES = 16
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // bus pins
   input wire logic [15:0] addressLines,
   input wire logic readNotWrite,
   input wire logic validAddressPin,
   input wire logic [7:0] dataLinesIn,
   input wire logic [7:0] dataLinesOut,
   input wire logic [7:0] dataLinesOe_n,
   input wire logic phaseOne,
   input wire logic phaseTwo
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////////////////
   // phase timing: two slots of phase one, three of phase two, never both
   property p_excl; phaseOne != phaseTwo && validAddressPin; endproperty
   a_excl: assert property (p_excl) else $error("phase overlap");
   property p_len; $rose(phaseOne) |=> phaseOne ##1 (!phaseOne)[*3] ##1 phaseOne; endproperty
   a_len: assert property (p_len) else $error("phase length");
   // address and direction only move in phase one
   property p_addr; phaseTwo |-> $stable(addressLines); endproperty
   a_addr: assert property (p_addr) else $error("address moved");
   property p_rnw; phaseTwo |-> $stable(readNotWrite); endproperty
   a_rnw: assert property (p_rnw) else $error("direction moved");
   // pins driven only in phase two of write cycles
   property p_oe; phaseTwo |-> dataLinesOe_n == {8{readNotWrite}}; endproperty
   a_oe: assert property (p_oe) else $error("enable wrong");
   property p_float; phaseOne |-> dataLinesOe_n == 8'hFF; endproperty
   a_float: assert property (p_float) else $error("driven in phase one");
   // a write lasts one machine cycle, the next is always a fetch
   property p_wr; $fell(readNotWrite) |=> (!readNotWrite)[*4] ##1 readNotWrite; endproperty
   a_wr: assert property (p_wr) else $error("write length");
   property p_mask; (addressLines >> ADDR_LINES) == 16'h0000; endproperty
   a_mask: assert property (p_mask) else $error("upper lines set");
endmodule : cpu_regsec_checker

bind cpu_register_section cpu_regsec_checker #(.ADDR_LINES(ADDR_LINES)) chkU (.clock, .nrst, .addressLines,
   .readNotWrite, .validAddressPin, .dataLinesIn, .dataLinesOut, .dataLinesOe_n, .phaseOne, .phaseTwo);

// File: sim/mem_model.sv
// memory and peripheral stand-in on the far side of the bus
`timescale 1ns/100ps
module mem_model (
   // bus as the support chips see it
   input wire logic clock,
   input wire logic phaseTwo,
   input wire logic readNotWrite,
   input wire logic [15:0] addressLines,
   input wire logic [7:0] dataBus,
   // data the memory offers
   output logic [7:0] memData
);
   logic [7:0] mem [65536];
   logic [7:0] junk = 8'h5A;
   initial foreach (mem[i]) mem[i] = 8'h00;
   ////////////////////////////////////////////////////////////////////////////
   // released bus flips every clock so stale data is never taken for a read
   always @(posedge clock) junk <= ~junk;
   assign memData = (phaseTwo && readNotWrite) ? mem[addressLines] : junk;
   // write data taken in phase two; the last slot wins
   always @(posedge clock) if (phaseTwo && !readNotWrite) mem[addressLines] <= dataBus;
endmodule : mem_model

// File: sim/tb_top.sv
// self-checking bench: small programs run from memory, results read back
`timescale 1ns/100ps
module tb_top;
   typedef struct packed {logic [7:0] op; logic [7:0] a; logic [7:0] b; logic [7:0] res;} row_t;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic [15:0] addressLines;
   logic readNotWrite;
   logic phaseTwo;
   logic [7:0] dataLinesOut;
   logic [7:0] dataLinesOe_n;
   logic [7:0] memData;
   logic [7:0] dataLinesIn;
   int miscompares = 0;
   int total_checks = 0;
   int cycles = 0;
   row_t rows [5] = '{'{cpu_regsec_pkg::OP_ADD_IMM, 8'h3C, 8'h0F, 8'h4B}, '{cpu_regsec_pkg::OP_ADD_IMM, 8'hFF,
      8'h01, 8'h00}, '{cpu_regsec_pkg::OP_AND_IMM, 8'hF0, 8'h3C, 8'h30}, '{cpu_regsec_pkg::OP_OR_IMM, 8'h0F,
      8'hA0, 8'hAF}, '{cpu_regsec_pkg::OP_XOR_IMM, 8'hFF, 8'h5A, 8'hA5}};
   // each data line resolves between design and memory drivers
   assign dataLinesIn = (dataLinesOut & ~dataLinesOe_n) | (memData & dataLinesOe_n);
   always #10 clock = ~clock;
   cpu_register_section #(.ADDR_LINES(13)) dut_u (.clock(clock), .nrst(nrst), .addressLines(addressLines),
      .readNotWrite(readNotWrite), .validAddressPin(), .dataLinesIn(dataLinesIn), .dataLinesOut(dataLinesOut),
      .dataLinesOe_n(dataLinesOe_n), .phaseOne(), .phaseTwo(phaseTwo));
   mem_model memU (.clock(clock), .phaseTwo(phaseTwo), .readNotWrite(readNotWrite), .addressLines(addressLines),
      .dataBus(dataLinesIn), .memData(memData));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   // eight program bytes, first byte at the lowest address
   task automatic put(input logic [15:0] at, input logic [63:0] prog);
      for (int i = 0; i < 8; i++) memU.mem[at + 16'(i)] = prog[63 - 8 * i -: 8];
   endtask : put
   // reset ten clocks around the load, then run n machine cycles
   task automatic start(input logic [63:0] prog, input int n);
      @(posedge clock);
      nrst <= 1'b0;
      put(16'h0000, prog);
      repeat (10) @(posedge clock);
      nrst <= 1'b1;
      repeat (5 * n) @(posedge clock);
   endtask : start
   // a hang is cut short well past the expected run length
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         miscompares++;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clock);
      #1;
      check(addressLines, 16'h0000);
      check({15'h0000, readNotWrite}, 16'h0001);
      check({8'h00, dataLinesOe_n}, 16'h00FF);
      $display("reset test done");
      // load an immediate, operate on a second one, store to 0280
      foreach (rows[i]) begin
         memU.mem[16'h0280] = ~rows[i].res;
         start({cpu_regsec_pkg::OP_LOAD_ACC_IMM, rows[i].a, rows[i].op, rows[i].b,
            cpu_regsec_pkg::OP_STORE_ACC_ABS, 8'h80, 8'h02, 8'h00}, 12);
         check({8'h00, memU.mem[16'h0280]}, {8'h00, rows[i].res});
         $display("row %0d done", i);
      end
      // jump to 2100, folded onto 0100 by the missing lines, then an indexed store wrapping in page zero
      put(16'h0100, {cpu_regsec_pkg::OP_LOAD_ACC_IMM, 8'h3C, cpu_regsec_pkg::OP_LOAD_X_IMM, 8'hFE,
         cpu_regsec_pkg::OP_INC_X, cpu_regsec_pkg::OP_STORE_ACC_ZPX, 8'h41, 8'h00});
      memU.mem[16'h0040] = 8'h00;
      start({cpu_regsec_pkg::OP_JUMP_ABS, 8'h00, 8'h21, 40'h0000000000}, 18);
      check({8'h00, memU.mem[16'h0040]}, 16'h003C);
      $display("index wrap test done");
      wrap_up();
   end
endmodule : tb_top
